// ==== hw/i2cst_top.sv ====
// Two-wire slave transmitter with status reporting and a plain register port.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module i2cst_top (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        arb_lost_addr,
  output logic             slave_rx_sel
);
  typedef struct packed {
    i2cst_pkg::i2cst_eng_t          st;
    logic                           flag;
    logic                           ack_en;
    logic                           start_request_bit;
    logic                           stop_request_bit;
    logic                           en;
    logic [i2cst_pkg::PRESC_W-1:0]  presc;
    logic [7:0]                     code;
    logic [7:0]                     data;
    logic [7:0]                     own;
    logic [7:0]                     shift;
    logic [3:0]                     cnt;
    logic                           last;
    logic                           mack;
    logic                           arb;
    logic                           rx_sel;
    logic                           sda_drv;
    logic                           scl_drv;
    logic                           sda_oe;
    logic                           scl_oe;
    logic                           sda_o;
    logic                           scl_o;
    logic [7:0]                     rdata;
    logic                           gen_req;
    logic                           gen_rel;
  } i2cst_top_t;

  i2cst_top_t q, d;
  i2cst_link_if lk ();

  i2cst_line_mon u_mon (
    .core_clk (core_clk),
    .rst      (rst),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .lk       (lk)
  );

  i2cst_start_gen u_gen (
    .core_clk (core_clk),
    .rst      (rst),
    .lk       (lk)
  );

  // Status byte as software sees it.
  function automatic logic [7:0] stat_byte(input logic flag, input logic [7:0] code,
                                           input logic [1:0] presc);
    logic [7:0] c;
    c = flag ? code : i2cst_pkg::ST_NO_INFO;
    return {c[7:3], 1'b0, presc};
  endfunction

  logic       wr_ctrl;
  logic       rel;
  logic       set_flag;
  logic [7:0] set_code;
  logic       mid_frame;
  logic       own_hit;
  logic       gc_hit;

  always_comb begin
    d          = q;
    d.gen_req  = 1'b0;
    d.gen_rel  = 1'b0;
    d.rdata    = '0;
    set_flag   = 1'b0;
    set_code   = q.code;
    wr_ctrl    = reg_wr && (reg_addr == i2cst_pkg::OFS_CTRL);
    // writing the flag as one lets the hardware proceed
    rel        = wr_ctrl && reg_wdata[i2cst_pkg::CTL_FLAG] && q.flag;
    own_hit    = 1'b0;
    gc_hit     = 1'b0;

    if (reg_rd) begin
      unique case (reg_addr)
        i2cst_pkg::OFS_CTRL: d.rdata = {q.flag, q.ack_en, q.start_request_bit, q.stop_request_bit, 1'b0, q.en, 2'b00};
        i2cst_pkg::OFS_STAT: d.rdata = stat_byte(q.flag, q.code, q.presc);
        i2cst_pkg::OFS_DATA: d.rdata = q.data;
        i2cst_pkg::OFS_OWN:  d.rdata = q.own;
      endcase
    end
    if (wr_ctrl) begin
      d.ack_en = reg_wdata[i2cst_pkg::CTL_ACK];
      d.start_request_bit    = reg_wdata[i2cst_pkg::CTL_STA];
      d.stop_request_bit    = reg_wdata[i2cst_pkg::CTL_STO];
      d.en     = reg_wdata[i2cst_pkg::CTL_EN];
    end
    if (reg_wr && reg_addr == i2cst_pkg::OFS_STAT) begin
      d.presc = reg_wdata[i2cst_pkg::PRESC_W-1:0];
    end
    if (reg_wr && reg_addr == i2cst_pkg::OFS_DATA) begin
      d.data = reg_wdata;
    end
    if (reg_wr && reg_addr == i2cst_pkg::OFS_OWN) begin
      d.own = reg_wdata;
    end
    if (arb_lost_addr) begin
      d.arb = 1'b1;
    end

    // START or STOP inside an address, data or acknowledge bit
    mid_frame = ((q.st == i2cst_pkg::E_ADDR) && (q.cnt != 4'h0)) ||
                (q.st == i2cst_pkg::E_AACK) || (q.st == i2cst_pkg::E_TX) ||
                (q.st == i2cst_pkg::E_TACK);

    if (!q.en) begin
      d.st      = i2cst_pkg::E_IDLE;
      d.sda_drv = 1'b0;
      d.scl_drv = 1'b0;
    end else if (lk.gen_done) begin
      // START sent once the bus was free
      set_flag  = 1'b1;
      set_code  = i2cst_pkg::ST_START_SENT;
      d.sda_drv = 1'b0;
      d.scl_drv = 1'b0;
      d.st      = i2cst_pkg::E_MST;
    end else if (mid_frame && (lk.start_p || lk.stop_p)) begin
      // bus error flags and posts its code
      set_flag  = 1'b1;
      set_code  = i2cst_pkg::ST_BUS_ERR;
      d.sda_drv = 1'b0;
      d.scl_drv = 1'b0;
      d.st      = i2cst_pkg::E_BERR;
    end else begin
      unique case (q.st)
        i2cst_pkg::E_IDLE, i2cst_pkg::E_IGN: begin
          // not addressed, data line stays released
          d.sda_drv = 1'b0;
          if (lk.start_p) begin
            d.st     = i2cst_pkg::E_ADDR;
            d.cnt    = '0;
            d.rx_sel = 1'b0;
          end else if (lk.stop_p) begin
            d.st     = i2cst_pkg::E_IDLE;
            d.rx_sel = 1'b0;
          end
        end
        i2cst_pkg::E_ADDR: begin
          // a START before the first address bit restarts the address byte; a later one is a bus error
          if (lk.start_p) begin
            d.cnt = '0;
          end else if (lk.stop_p) begin
            d.st = i2cst_pkg::E_IDLE;
          end else if (lk.scl_rise && q.cnt != i2cst_pkg::BYTE_BITS) begin
            d.shift = {q.shift[6:0], lk.sda_lvl};
            d.cnt   = q.cnt + 4'h1;
          end else if (lk.scl_fall && q.cnt == i2cst_pkg::BYTE_BITS) begin
            // no recognition while ack-enable is low
            own_hit = q.ack_en && (q.shift[7:1] == q.own[7:1]);
            gc_hit  = q.ack_en && q.own[0] && (q.shift[7:1] == i2cst_pkg::GC_ADDR) &&
                      (q.shift[0] != i2cst_pkg::RW_READ);
            // read selects transmit, write hands over to the receiver
            if (own_hit && q.shift[0] == i2cst_pkg::RW_READ) begin
              d.sda_drv = 1'b1;
              d.st      = i2cst_pkg::E_AACK;
            end else begin
              d.rx_sel = own_hit || gc_hit;
              d.st     = i2cst_pkg::E_IGN;
              d.arb    = 1'b0;
            end
          end
        end
        i2cst_pkg::E_AACK: begin
          if (lk.scl_fall) begin
            // arbitration was lost in the address phase
            // hold the clock while software answers
            set_flag  = 1'b1;
            set_code  = q.arb ? i2cst_pkg::ST_ARB_READ : i2cst_pkg::ST_OWN_READ;
            d.arb     = 1'b0;
            d.sda_drv = 1'b0;
            d.scl_drv = 1'b1;
            d.st      = i2cst_pkg::E_WAIT;
          end
        end
        i2cst_pkg::E_TX: begin
          if (lk.scl_fall) begin
            if (q.cnt == i2cst_pkg::BYTE_BITS - 4'h1) begin
              d.sda_drv = 1'b0;
              d.st      = i2cst_pkg::E_TACK;
            end else begin
              d.cnt     = q.cnt + 4'h1;
              d.shift   = {q.shift[6:0], 1'b1};
              d.sda_drv = ~q.shift[6];
            end
          end
        end
        i2cst_pkg::E_TACK: begin
          if (lk.scl_rise) begin
            d.mack = ~lk.sda_lvl;
          end else if (lk.scl_fall) begin
            set_flag  = 1'b1;
            d.scl_drv = 1'b1;
            d.st      = i2cst_pkg::E_WAIT;
            if (!q.mack) begin
              set_code = i2cst_pkg::ST_DATA_NACK;
            end else if (q.last) begin
              set_code = i2cst_pkg::ST_LAST_ACK;
            end else begin
              set_code = i2cst_pkg::ST_DATA_ACK;
            end
          end
        end
        i2cst_pkg::E_WAIT: begin
          if (rel) begin
            d.scl_drv = 1'b0;
            if (q.code == i2cst_pkg::ST_DATA_NACK || q.code == i2cst_pkg::ST_LAST_ACK) begin
              // start bit asks for a START when the bus frees
              d.st      = i2cst_pkg::E_IGN;
              d.gen_req = reg_wdata[i2cst_pkg::CTL_STA];
            end else begin
              // ack-enable low marks this byte as the last one
              d.last    = ~reg_wdata[i2cst_pkg::CTL_ACK];
              d.shift   = q.data;
              d.sda_drv = ~q.data[7];
              d.cnt     = '0;
              d.st      = i2cst_pkg::E_TX;
            end
          end
        end
        i2cst_pkg::E_BERR: begin
          if (rel && reg_wdata[i2cst_pkg::CTL_STO]) begin
            // only the stop bit is cleared
            // lines already released, no STOP is driven
            d.stop_request_bit = 1'b0;
            d.st  = i2cst_pkg::E_IDLE;
          end
        end
        i2cst_pkg::E_MST: begin
          if (rel) begin
            d.gen_rel = 1'b1;
            d.stop_request_bit     = 1'b0;
            d.start_request_bit     = 1'b0;
            d.st      = i2cst_pkg::E_IDLE;
          end
        end
      endcase
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    if (set_flag) begin
      d.flag = 1'b1;
      d.code = set_code;
    end else if (wr_ctrl && reg_wdata[i2cst_pkg::CTL_FLAG]) begin
      d.flag = 1'b0;
    end

    d.sda_oe = q.sda_drv | lk.gen_sda_pull;
    d.scl_oe = q.scl_drv | lk.gen_scl_pull;
  end

  assign lk.gen_req = q.gen_req;
  assign lk.gen_rel = q.gen_rel;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '{st: i2cst_pkg::E_IDLE, code: i2cst_pkg::ST_NO_INFO,
             data: i2cst_pkg::DATA_RST, own: i2cst_pkg::OWN_RST,
             shift: 8'hff, cnt: 4'h0, presc: '0, rdata: 8'h00, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  // status compare needs the prescaler masked; the low bits carry it as written.
  assign reg_rdata    = q.rdata;
  assign scl_out      = q.scl_o;
  assign scl_oe       = q.scl_oe;
  assign sda_out      = q.sda_o;
  assign sda_oe       = q.sda_oe;
  assign slave_rx_sel = q.rx_sel;
endmodule

// ==== pkg/i2cst_pkg.sv ====
// Shared constants and types of the two-wire slave-transmitter block.
package i2cst_pkg;

  // Status codes posted in the upper five bits of the status register.
  localparam logic [7:0] ST_OWN_READ   = 8'ha8;
  localparam logic [7:0] ST_ARB_READ   = 8'hb0;
  localparam logic [7:0] ST_DATA_ACK   = 8'hb8;
  localparam logic [7:0] ST_DATA_NACK  = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK   = 8'hc8;
  localparam logic [7:0] ST_NO_INFO    = 8'hf8;
  localparam logic [7:0] ST_BUS_ERR    = 8'h00;
  localparam logic [7:0] ST_START_SENT = 8'h08;

  // Register offsets on the plain register port.
  localparam int         ADDR_W   = 2;
  localparam logic [1:0] OFS_CTRL = 2'h0;
  localparam logic [1:0] OFS_STAT = 2'h1;
  localparam logic [1:0] OFS_DATA = 2'h2;
  localparam logic [1:0] OFS_OWN  = 2'h3;

  // Control register bit positions.
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK  = 6;
  localparam int CTL_STA  = 5;
  localparam int CTL_STO  = 4;
  localparam int CTL_EN   = 2;

  // Status register layout: code in bits 7..3, prescaler in bits 1..0.
  localparam int PRESC_W = 2;

  // Reset values.
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [7:0] OWN_RST  = 8'h00;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] GC_ADDR   = 7'h00;
  localparam logic       RW_READ   = 1'b1;

  // Bus timing for a START issued by this block.
  localparam int CLK_MHZ       = 200;
  localparam int BUS_FREE_NS   = 4700;
  localparam int START_HOLD_NS = 4000;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int BUS_FREE_CYC   = cyc_up(BUS_FREE_NS);
  localparam int START_HOLD_CYC = cyc_up(START_HOLD_NS);

  typedef enum logic [8:0] {
    E_IDLE = 9'h001,
    E_ADDR = 9'h002,
    E_AACK = 9'h004,
    E_TX   = 9'h008,
    E_TACK = 9'h010,
    E_WAIT = 9'h020,
    E_IGN  = 9'h040,
    E_BERR = 9'h080,
    E_MST  = 9'h100
  } i2cst_eng_t;

  typedef enum logic [4:0] {
    G_IDLE = 5'h01,
    G_WAIT = 5'h02,
    G_HOLD = 5'h04,
    G_OWN  = 5'h08,
    G_STOP = 5'h10
  } i2cst_gen_t;

endpackage

// ==== pkg/i2cst_link_if.sv ====
// Line events and START generator handshake between the block's modules.
`timescale 1ns/1ps
interface i2cst_link_if;
  logic scl_rise;
  logic scl_fall;
  logic start_p;
  logic stop_p;
  logic sda_lvl;
  logic busy;
  logic gen_req;
  logic gen_rel;
  logic gen_done;
  logic gen_sda_pull;
  logic gen_scl_pull;

  modport mon (output scl_rise, output scl_fall, output start_p, output stop_p,
               output sda_lvl, output busy);
  modport gen (input busy, input gen_req, input gen_rel, output gen_done,
               output gen_sda_pull, output gen_scl_pull);
  modport eng (input scl_rise, input scl_fall, input start_p, input stop_p,
               input sda_lvl, input busy, output gen_req, output gen_rel,
               input gen_done, input gen_sda_pull, input gen_scl_pull);
endinterface

// ==== hw/i2cst_line_mon.sv ====
// Synchronises the bus lines and finds clock edges, START and STOP.
`timescale 1ns/1ps
module i2cst_line_mon (
  input  wire logic   core_clk,
  input  wire logic   rst,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  i2cst_link_if.mon   lk
);
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl_l;
    logic       sda_l;
    logic       rise;
    logic       fall;
    logic       start_request_bit;
    logic       stop_request_bit;
    logic       busy;
  } i2cst_mon_t;

  i2cst_mon_t q, d;

  always_comb begin
    d       = q;
    d.scl_s = {q.scl_s[1:0], scl_in};
    d.sda_s = {q.sda_s[1:0], sda_in};
    // A level counts only once the second and third stages agree.
    if (q.scl_s[1] == q.scl_s[2]) begin
      d.scl_l = q.scl_s[2];
    end
    if (q.sda_s[1] == q.sda_s[2]) begin
      d.sda_l = q.sda_s[2];
    end
    d.rise = d.scl_l & ~q.scl_l;
    d.fall = ~d.scl_l & q.scl_l;
    d.start_request_bit  = q.scl_l & d.scl_l & q.sda_l & ~d.sda_l;
    d.stop_request_bit  = q.scl_l & d.scl_l & ~q.sda_l & d.sda_l;
    if (d.start_request_bit) begin
      d.busy = 1'b1;
    end else if (d.stop_request_bit) begin
      d.busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '{scl_s: 3'h7, sda_s: 3'h7, scl_l: 1'b1, sda_l: 1'b1, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign lk.scl_rise = q.rise;
  assign lk.scl_fall = q.fall;
  assign lk.start_p  = q.start_request_bit;
  assign lk.stop_p   = q.stop_request_bit;
  assign lk.sda_lvl  = q.sda_l;
  assign lk.busy     = q.busy;
endmodule

// ==== hw/i2cst_start_gen.sv ====
// Issues a START once the bus is free, holds it, and later closes with a STOP.
`timescale 1ns/1ps
module i2cst_start_gen #(
  parameter int CNT_W    = 10,
  parameter int FREE_CYC = i2cst_pkg::BUS_FREE_CYC,
  parameter int HOLD_CYC = i2cst_pkg::START_HOLD_CYC
) (
  input  wire logic   core_clk,
  input  wire logic   rst,
  i2cst_link_if.gen   lk
);
  if (FREE_CYC >= (1 << CNT_W) || HOLD_CYC >= (1 << CNT_W) || FREE_CYC < 1 || HOLD_CYC < 1) begin
    $error("Start generator counts do not fit the counter width.");
  end

  localparam logic [CNT_W-1:0] FREE_LAST = CNT_W'(FREE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);

  typedef struct packed {
    i2cst_pkg::i2cst_gen_t st;
    logic [CNT_W-1:0]      cnt;
    logic                  sda_pull;
    logic                  scl_pull;
    logic                  done;
  } i2cst_sg_t;

  i2cst_sg_t q, d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    unique case (q.st)
      i2cst_pkg::G_IDLE: begin
        d.cnt = '0;
        if (lk.gen_req) begin
          d.st = i2cst_pkg::G_WAIT;
        end
      end
      i2cst_pkg::G_WAIT: begin
        // Any bus activity restarts the free-time count.
        if (lk.busy) begin
          d.cnt = '0;
        end else if (q.cnt == FREE_LAST) begin
          d.cnt      = '0;
          d.sda_pull = 1'b1;
          d.st       = i2cst_pkg::G_HOLD;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      i2cst_pkg::G_HOLD: begin
        if (q.cnt == HOLD_LAST) begin
          d.cnt      = '0;
          d.scl_pull = 1'b1;
          d.done     = 1'b1;
          d.st       = i2cst_pkg::G_OWN;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      i2cst_pkg::G_OWN: begin
        if (lk.gen_rel) begin
          d.scl_pull = 1'b0;
          d.st       = i2cst_pkg::G_STOP;
        end
      end
      i2cst_pkg::G_STOP: begin
        if (q.cnt == HOLD_LAST) begin
          d.sda_pull = 1'b0;
          d.st       = i2cst_pkg::G_IDLE;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '{st: i2cst_pkg::G_IDLE, cnt: '0, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign lk.gen_done     = q.done;
  assign lk.gen_sda_pull = q.sda_pull;
  assign lk.gen_scl_pull = q.scl_pull;
endmodule

// ==== verif/i2cst_props.sv ====
// Concurrent checks on the slave transmitter's register port and line drivers.
`timescale 1ns/1ps
module i2cst_props (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       scl_oe,
  input wire logic       sda_oe,
  input wire logic       slave_rx_sel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       wctl, rctl, rsts, wrel, wrec, iso_q;
  logic [1:0] presc_q;
  assign wctl = reg_wr && reg_addr == i2cst_pkg::OFS_CTRL;
  assign rctl = reg_rd && reg_addr == i2cst_pkg::OFS_CTRL;
  assign rsts = reg_rd && reg_addr == i2cst_pkg::OFS_STAT;
  assign wrel = wctl && reg_wdata[7];
  assign wrec = wrel && reg_wdata[4];
  // Isolation is only tracked when ack-enable drops outside a stretch.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_q <= 2'h0;
      iso_q   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == i2cst_pkg::OFS_STAT) begin
        presc_q <= reg_wdata[1:0];
      end
      if (wctl) begin
        iso_q <= !reg_wdata[6] && !scl_oe;
      end
    end
  end
  property p_code_hi; rsts |=> reg_rdata[2] == 1'b0; endproperty
  a_code_hi: assert property (p_code_hi) else $error("status bit two set");
  property p_presc; rsts |=> reg_rdata[1:0] == presc_q; endproperty
  a_presc: assert property (p_presc) else $error("prescaler bits lost");
  property p_noinfo; wrel ##[1:2] rsts |=> reg_rdata[7:3] == 5'h1f; endproperty
  a_noinfo: assert property (p_noinfo) else $error("no 0xf8 after flag clear");
  // The line driver lags a release write by up to three cycles.
  property p_hold; scl_oe && !wrel && !$past(wrel) && !$past(wrel, 2) |=> scl_oe; endproperty
  a_hold: assert property (p_hold) else $error("clock let go early");
  property p_let; scl_oe && wrel && !reg_wdata[4] |-> ##[1:3] !scl_oe; endproperty
  a_let: assert property (p_let) else $error("clock not let go");
  property p_rec; wrec |=> (!sda_oe && !scl_oe) [*8]; endproperty
  a_rec: assert property (p_rec) else $error("line driven on recovery");
  property p_sto; wrec ##[1:2] rctl |=> !reg_rdata[4]; endproperty
  a_sto: assert property (p_sto) else $error("stop bit not cleared");
  property p_iso; iso_q |-> !sda_oe; endproperty
  a_iso: assert property (p_iso) else $error("data driven while isolated");
  c_own: cover property (rsts ##1 reg_rdata[7:3] == 5'h15);
  c_str: cover property ($rose(scl_oe));
  c_rx: cover property ($rose(slave_rx_sel));
endmodule
bind i2cst_top i2cst_props i_props (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .scl_oe, .sda_oe, .slave_rx_sel);

// ==== verif/i2cst_bus_master.sv ====
// Remote bus master model: open-drain clock and data, honours clock stretching.
`timescale 1ns/1ps
module i2cst_bus_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  localparam realtime Q = 31.25;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // A stretched clock is waited for, but a stuck line ends the run.
  task automatic rel_scl();
    int n;
    scl_low = 1'b0;
    for (n = 0; n < 900 && scl !== 1'b1; n++) #5;
    if (scl !== 1'b1) tb.timed_out();
  endtask
  // start without giving up the bus
  task automatic start();
    #Q sda_low = 1'b0;
    #Q rel_scl();
    #Q sda_low = 1'b1;
    #(Q - 1.0) scl_low = 1'b1;
    #1;
  endtask
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q rel_scl();
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // Data moves a quarter bit after the falling clock, so it never looks like a frame edge.
  task automatic bit_x(input logic b, output logic r);
    #Q sda_low = !b;
    #Q rel_scl();
    #Q r = sda;
    // The clock falls a nanosecond early so no line moves on a core clock edge.
    #(Q - 1.0) scl_low = 1'b1;
    #1;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q,
                      output logic sa);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ma, sa);
  endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench: register port stimulus plus a remote master on the two lines.
`timescale 1ns/1ps
module tb;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       arb_lost_addr = 1'b0;
  logic [7:0] reg_rdata, rd_q, q;
  logic       scl_oe, sda_oe, scl_out, sda_out, scl_low, sda_low, slave_rx_sel, a;
  wire logic  scl, sda;
  int         fail_count = 0;
  int         total_checks = 0;
  assign scl = !((scl_oe && !scl_out) || scl_low);
  assign sda = !((sda_oe && !sda_out) || sda_low);
  always #2.5 core_clk = !core_clk;
  i2cst_top i_dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe,
    .arb_lost_addr, .slave_rx_sel);
  i2cst_bus_master i_mst (.scl, .sda, .scl_low, .sda_low);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic final_report();
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic timed_out();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    final_report();
  endtask
  // A spare cycle after each strobe keeps one assignment per signal per step.
  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [1:0] ad);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic stat(input logic [7:0] exp);
    rd(i2cst_pkg::OFS_STAT);
    chk(rd_q & 8'hf8, exp);
  endtask
  task automatic wait_oe(input logic sel, input logic v);
    int n;
    @(posedge core_clk);
    for (n = 0; n < 4000 && (sel ? scl_oe : sda_oe) !== v; n++) @(posedge core_clk);
    if (n == 4000) timed_out();
  endtask
  task automatic t_read();
    stat(i2cst_pkg::ST_NO_INFO);
    wr(i2cst_pkg::OFS_OWN, 8'ha5);
    rd(i2cst_pkg::OFS_OWN);
    chk(rd_q, 8'ha5);
    wr(i2cst_pkg::OFS_STAT, 8'h03);
    wr(i2cst_pkg::OFS_CTRL, 8'h44);
    i_mst.start();
    i_mst.xfer(8'ha5, 1'b1, q, a);
    chk1(a, 1'b0);
    wait_oe(1'b1, 1'b1);
    stat(i2cst_pkg::ST_OWN_READ);
    chk(rd_q, 8'hab);
    wr(i2cst_pkg::OFS_DATA, 8'h5a);
    rd(i2cst_pkg::OFS_DATA);
    chk(rd_q, 8'h5a);
    wr(i2cst_pkg::OFS_CTRL, 8'hc4);
    i_mst.xfer(8'hff, 1'b0, q, a);
    chk(q, 8'h5a);
    wait_oe(1'b1, 1'b1);
    stat(i2cst_pkg::ST_DATA_ACK);
    wr(i2cst_pkg::OFS_DATA, 8'h81);
    wr(i2cst_pkg::OFS_CTRL, 8'h84);
    i_mst.xfer(8'hff, 1'b0, q, a);
    chk(q, 8'h81);
    wait_oe(1'b1, 1'b1);
    stat(i2cst_pkg::ST_LAST_ACK);
    wr(i2cst_pkg::OFS_CTRL, 8'hc4);
    stat(i2cst_pkg::ST_NO_INFO);
    i_mst.xfer(8'hff, 1'b1, q, a);
    chk(q, 8'hff);
    i_mst.stop();
  endtask
  task automatic t_arb_start();
    i_mst.start();
    i_mst.xfer({7'h33, 1'b0}, 1'b1, q, a);
    chk1(a, 1'b1);
    @(posedge core_clk);
    arb_lost_addr <= 1'b1;
    @(posedge core_clk);
    arb_lost_addr <= 1'b0;
    i_mst.start();
    i_mst.xfer(8'ha5, 1'b1, q, a);
    wait_oe(1'b1, 1'b1);
    stat(i2cst_pkg::ST_ARB_READ);
    wr(i2cst_pkg::OFS_DATA, 8'hc3);
    wr(i2cst_pkg::OFS_CTRL, 8'h84);
    i_mst.xfer(8'hff, 1'b1, q, a);
    chk(q, 8'hc3);
    wait_oe(1'b1, 1'b1);
    stat(i2cst_pkg::ST_DATA_NACK);
    wr(i2cst_pkg::OFS_CTRL, 8'he4);
    i_mst.stop();
    wait_oe(1'b0, 1'b1);
    chk1(scl, 1'b1);
    wait_oe(1'b1, 1'b1);
    stat(i2cst_pkg::ST_START_SENT);
    wr(i2cst_pkg::OFS_CTRL, 8'hc4);
    wait_oe(1'b0, 1'b0);
  endtask
  task automatic t_noack();
    wr(i2cst_pkg::OFS_CTRL, 8'h04);
    i_mst.start();
    i_mst.xfer(8'ha5, 1'b1, q, a);
    chk1(a, 1'b1);
    i_mst.stop();
    @(posedge core_clk);
    wr(i2cst_pkg::OFS_CTRL, 8'h44);
    i_mst.start();
    i_mst.xfer(8'ha4, 1'b1, q, a);
    chk1(a, 1'b1);
    #40;
    chk1(slave_rx_sel, 1'b1);
    i_mst.start();
    i_mst.xfer(8'h00, 1'b1, q, a);
    chk1(a, 1'b1);
    #40;
    chk1(slave_rx_sel, 1'b1);
    i_mst.stop();
    #40;
    chk1(slave_rx_sel, 1'b0);
  endtask
  task automatic t_berr();
    i_mst.start();
    repeat (3) i_mst.bit_x(1'b0, a);
    i_mst.stop();
    repeat (10) @(posedge core_clk);
    stat(i2cst_pkg::ST_BUS_ERR);
    chk1(sda_oe || scl_oe, 1'b0);
    wr(i2cst_pkg::OFS_CTRL, 8'hd4);
    rd(i2cst_pkg::OFS_CTRL);
    chk(rd_q, 8'h44);
    stat(i2cst_pkg::ST_NO_INFO);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_read();
    t_arb_start();
    t_noack();
    t_berr();
    final_report();
  end
endmodule
